// *** shared/ums_defs.vh ***
// Constants of the update-mode measurement scheduler
`ifndef UMS_DEFS_VH
`define UMS_DEFS_VH

// Clock rate
`define UMS_CLK_KHZ           25000

// Power-down settings, in microseconds
`define UMS_PD_SEL_NONE       2'b00
`define UMS_PD_US_0           0
`define UMS_PD_US_1           5000
`define UMS_PD_US_2           25000
`define UMS_PD_US_3           125000

// Conversion times per resolution code, in microseconds
`define UMS_CONV_US_0         300
`define UMS_CONV_US_1         1150
`define UMS_CONV_US_2         4500
`define UMS_CONV_US_3         18000

// Fixed overhead of a measurement cycle, in microseconds
`define UMS_WAKE_US           100
`define UMS_CAP_CALC_US       300
`define UMS_TEMP_CALC_US      250

// Temperature runs once per this many capacitance cycles
`define UMS_TEMP_EVERY        6
`define UMS_TEMP_CNT_RESET    3'h0

// Worst-case scale applied to typical times, in tenths
`define UMS_WORST_TENTHS      11

// Microseconds to cycles (least time, rounded up)
`define UMS_US2CYC(us) ((((us) * `UMS_CLK_KHZ) + 999) / 1000)

`endif

// *** src/ums_sched.v ***
// Update-mode measurement scheduler: cycle sequencing and output update
`timescale 1ns/1ns
`include "ums_defs.vh"

module ums_sched (
   input  wire        mclk_in,
   input  wire        rst_in,
   input  wire        update_mode_in,
   input  wire [1:0]  pd_sel_in,
   input  wire [1:0]  cap_res_in,
   input  wire [1:0]  temp_res_in,
   input  wire [3:0]  cap_mult_in,
   input  wire        worst_case_in,
   input  wire [15:0] cap_result_in,
   input  wire [15:0] temp_result_in,
   input  wire [1:0]  alarm_in,
   output reg  [15:0] output_reg_out,
   output reg  [15:0] temp_reg_out,
   output reg  [15:0] pulse_density_output_cap_out,
   output reg  [15:0] pulse_density_output_temp_out,
   output reg  [1:0]  alarm_out,
   output reg         data_ready_out,
   output wire        temp_conv_out,
   output wire        cap_conv_out,
   output wire        powered_down_out,
   output reg         cycle_done_out
);
   // ****************************************
   // States
   // ****************************************
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_WAKE  = 3'h1;
   localparam [2:0] ST_TCONV = 3'h2;
   localparam [2:0] ST_TCALC = 3'h3;
   localparam [2:0] ST_CCONV = 3'h4;
   localparam [2:0] ST_CCALC = 3'h5;
   localparam [2:0] ST_UPD   = 3'h6;
   localparam [2:0] ST_PDOWN = 3'h7;

   localparam [31:0] WAKE_CYC  = `UMS_US2CYC(`UMS_WAKE_US);
   localparam [31:0] CCALC_CYC = `UMS_US2CYC(`UMS_CAP_CALC_US);
   localparam [31:0] TCALC_CYC = `UMS_US2CYC(`UMS_TEMP_CALC_US);

   reg [2:0]  state_r;
   reg [2:0]  state_nxt;
   reg [2:0]  tcnt_r;
   reg [2:0]  tcnt_nxt;
   reg        load;
   reg [31:0] load_cyc;
   wire       tmr_done;

   // ****************************************
   // Time lookups
   // ****************************************
   function [31:0] conv_cyc;
      input [1:0] res;
      begin
         case (res)
            2'b00:   conv_cyc = `UMS_US2CYC(`UMS_CONV_US_0);
            2'b01:   conv_cyc = `UMS_US2CYC(`UMS_CONV_US_1);
            2'b10:   conv_cyc = `UMS_US2CYC(`UMS_CONV_US_2);
            default: conv_cyc = `UMS_US2CYC(`UMS_CONV_US_3);
         endcase
      end
   endfunction

   function [31:0] pd_cyc;
      input [1:0] sel;
      begin
         case (sel)
            2'b00:   pd_cyc = `UMS_US2CYC(`UMS_PD_US_0);
            2'b01:   pd_cyc = `UMS_US2CYC(`UMS_PD_US_1);
            2'b10:   pd_cyc = `UMS_US2CYC(`UMS_PD_US_2);
            default: pd_cyc = `UMS_US2CYC(`UMS_PD_US_3);
         endcase
      end
   endfunction

   // Worst-case stretch; result after x1.1 is rounded up to the next whole cycle
   function [31:0] scale;
      input [31:0] cyc;
      input        worst;
      begin
         scale = worst ? ((cyc * `UMS_WORST_TENTHS) + 32'd9) / 32'd10 : cyc;
      end
   endfunction

   wire [31:0] mult_ext = {28'h0000000, (cap_mult_in == 4'h0) ? 4'h1 : cap_mult_in};

   // ****************************************
   // Sequencer
   // ****************************************
   always @* begin
      state_nxt = state_r;
      tcnt_nxt  = tcnt_r;
      load      = 1'b0;
      load_cyc  = 32'h0;
      case (state_r)
         ST_IDLE: begin
            tcnt_nxt = `UMS_TEMP_CNT_RESET;
            if (update_mode_in) begin
               state_nxt = ST_WAKE;
               load      = 1'b1;
               load_cyc  = scale(WAKE_CYC, worst_case_in);
            end
         end
         ST_WAKE: if (tmr_done) begin
            load = 1'b1;
            if (tcnt_r == `UMS_TEMP_CNT_RESET) begin
               state_nxt = ST_TCONV;
               load_cyc  = scale(conv_cyc(temp_res_in), worst_case_in);
            end else begin
               state_nxt = ST_CCONV;
               load_cyc  = scale(conv_cyc(cap_res_in) * mult_ext, worst_case_in);
            end
         end
         ST_TCONV: if (tmr_done) begin
            state_nxt = ST_TCALC;
            load      = 1'b1;
            load_cyc  = scale(TCALC_CYC, worst_case_in);
         end
         ST_TCALC: if (tmr_done) begin
            state_nxt = ST_CCONV;
            load      = 1'b1;
            load_cyc  = scale(conv_cyc(cap_res_in) * mult_ext, worst_case_in);
         end
         ST_CCONV: if (tmr_done) begin
            state_nxt = ST_CCALC;
            load      = 1'b1;
            load_cyc  = scale(CCALC_CYC, worst_case_in);
         end
         ST_CCALC: if (tmr_done) begin
            state_nxt = ST_UPD;
            tcnt_nxt  = (tcnt_r == `UMS_TEMP_EVERY - 1) ? 3'h0 : tcnt_r + 3'h1;
         end
         ST_UPD: begin
            if (!update_mode_in) begin
               state_nxt = ST_IDLE;
            end else if (pd_sel_in == `UMS_PD_SEL_NONE) begin
               state_nxt = ST_WAKE;
               load      = 1'b1;
               load_cyc  = scale(WAKE_CYC, worst_case_in);
            end else begin
               state_nxt = ST_PDOWN;
               load      = 1'b1;
               load_cyc  = scale(pd_cyc(pd_sel_in), worst_case_in);
            end
         end
         ST_PDOWN: begin
            if (!update_mode_in) begin
               state_nxt = ST_IDLE;
            end else if (tmr_done) begin
               state_nxt = ST_WAKE;
               load      = 1'b1;
               load_cyc  = scale(WAKE_CYC, worst_case_in);
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // Single timer shared by all phases
   ums_timer u_timer (
      .mclk_in   (mclk_in),
      .rst_in    (rst_in),
      .load_in   (load),
      .cycles_in (load_cyc),
      .done_out  (tmr_done)
   );

   assign temp_conv_out    = (state_r == ST_TCONV);
   assign cap_conv_out     = (state_r == ST_CCONV);
   assign powered_down_out = (state_r == ST_PDOWN) || (state_r == ST_IDLE);

   // ****************************************
   // State and output update
   // ****************************************
   always @(posedge mclk_in) begin
      if (rst_in) begin
         state_r                       <= ST_IDLE;
         tcnt_r                        <= `UMS_TEMP_CNT_RESET;
         output_reg_out                <= 16'h0000;
         temp_reg_out                  <= 16'h0000;
         pulse_density_output_cap_out  <= 16'h0000;
         pulse_density_output_temp_out <= 16'h0000;
         alarm_out                     <= 2'h0;
         data_ready_out                <= 1'b0;
         cycle_done_out                <= 1'b0;
      end else begin
         state_r        <= state_nxt;
         tcnt_r         <= tcnt_nxt;
         cycle_done_out <= 1'b0;
         if (state_r == ST_TCALC && tmr_done) begin
            temp_reg_out                  <= temp_result_in;
            pulse_density_output_temp_out <= temp_result_in;
         end
         if (state_r == ST_WAKE) begin
            data_ready_out <= 1'b0;
         end
         // Capacitance, density-cap, alarm and ready outputs refresh together in the update state
         if (state_r == ST_UPD) begin
            output_reg_out               <= cap_result_in;
            pulse_density_output_cap_out <= cap_result_in;
            alarm_out                    <= alarm_in;
            data_ready_out               <= 1'b1;
            cycle_done_out               <= 1'b1;
         end
      end
   end
endmodule

// *** src/ums_timer.v ***
// Down-counting interval timer for one phase of the scheduler
`timescale 1ns/1ns
module ums_timer (
   input  wire        mclk_in,
   input  wire        rst_in,
   input  wire        load_in,
   input  wire [31:0] cycles_in,
   output wire        done_out
);
   reg [31:0] cnt_r;
   reg [31:0] cnt_nxt;
   reg        run_r;
   reg        run_nxt;

   assign done_out = run_r && (cnt_r == 32'h0000_0001);

   always @* begin
      cnt_nxt = cnt_r;
      run_nxt = run_r;
      if (load_in) begin
         cnt_nxt = (cycles_in == 32'h0) ? 32'h0000_0001 : cycles_in;
         run_nxt = 1'b1;
      end else if (run_r) begin
         cnt_nxt = cnt_r - 32'h0000_0001;
         if (cnt_r == 32'h0000_0001) begin
            run_nxt = 1'b0;
         end
      end
   end

   always @(posedge mclk_in) begin
      if (rst_in) begin
         cnt_r <= 32'h0;
         run_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         run_r <= run_nxt;
      end
   end
endmodule

// *** testbench/test_ums_sched.sv ***
// Self-checking bench of the update-mode scheduler
`timescale 1ns/1ns
module test_ums_sched;
   reg         mclk_in = 1'b0, rst_in = 1'b1, mode = 1'b0, worst = 1'b0;
   reg  [1:0]  pd_sel = 2'h0, alarm = 2'h2, cap_code = 2'h0, temp_code = 2'h0;
   reg  [3:0]  mult = 4'h1;
   reg  [15:0] cap_res = 16'h1234, temp_res = 16'h0abc;
   wire [15:0] out_w, temp_w, pdc_w, pdt_w;
   wire [1:0]  alarm_w;
   wire        ready_w, tconv_w, cconv_w, pd_w, done_w;
   integer     fails = 0, check_count = 0, cyc = 0, tcnt, ccnt, n1, n2, n3;
   always #20 mclk_in = ~mclk_in;
   ums_sched ums_sched_i (.mclk_in(mclk_in), .rst_in(rst_in), .update_mode_in(mode),
      .pd_sel_in(pd_sel), .cap_res_in(cap_code), .temp_res_in(temp_code), .cap_mult_in(mult),
      .worst_case_in(worst), .cap_result_in(cap_res), .temp_result_in(temp_res),
      .alarm_in(alarm), .output_reg_out(out_w), .temp_reg_out(temp_w),
      .pulse_density_output_cap_out(pdc_w), .pulse_density_output_temp_out(pdt_w),
      .alarm_out(alarm_w), .data_ready_out(ready_w), .temp_conv_out(tconv_w),
      .cap_conv_out(cconv_w), .powered_down_out(pd_w), .cycle_done_out(done_w));
   task stop_test;
      begin
         if (fails == 0 && check_count > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] lo, input [31:0] hi, input string what);
      begin
         check_count = check_count + 1;
         if ((got >= lo && got <= hi) !== 1'b1) begin
            fails = fails + 1;
            $display("BAD %0t %0s got %0d", $time, what, got);
         end
      end
   endtask
   // Counts clocks and conversion clocks up to the next update
   task wait_done(output integer n);
      begin
         n = 0;
         tcnt = 0;
         ccnt = 0;
         // First step always taken, so the pulse still showing at the call is skipped
         do begin
            @(negedge mclk_in);
            n = n + 1;
            tcnt = tcnt + (tconv_w === 1'b1);
            ccnt = ccnt + (cconv_w === 1'b1);
         end while (done_w !== 1'b1 && n < 40000);
         if (done_w !== 1'b1) begin
            fails = fails + 1;
            $display("BAD %0t no cycle end", $time);
         end
      end
   endtask
   // ************************************************************
   // Timeout and main sequence
   // ************************************************************
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         fails = fails + 1;
         stop_test;
      end
   end
   initial begin
      repeat (3) @(posedge mclk_in);
      rst_in <= 1'b0;
      @(negedge mclk_in);
      chk(pd_w, 1, 1, "idle after reset");
      @(posedge mclk_in);
      mode <= 1'b1;
      wait_done(n1);
      chk(tcnt, 7500, 7500, "first cycle temperature");
      chk(out_w, 16'h1234, 16'h1234, "output register");
      chk(pdc_w, 16'h1234, 16'h1234, "density cap");
      chk(pdt_w, 16'h0abc, 16'h0abc, "density temp");
      chk(alarm_w, 2, 2, "alarm");
      chk(ready_w, 1, 1, "data ready");
      @(posedge mclk_in);
      cap_res <= 16'h5678;
      temp_res <= 16'hbeef;
      alarm <= 2'h1;
      wait_done(n2);
      chk(n2, 17500, 17502, "cap-only period");
      chk(n1 - n2, 13749, 13753, "temperature portion");
      chk(tcnt, 0, 0, "temperature in second cycle");
      chk(ccnt, 7500, 7500, "cap conversion");
      chk(temp_w, 16'h0abc, 16'h0abc, "temperature kept");
      chk(out_w, 16'h5678, 16'h5678, "output register");
      chk(alarm_w, 1, 1, "alarm");
      @(posedge mclk_in);
      mult <= 4'h2;
      worst <= 1'b1;
      pd_sel <= 2'h1;
      wait_done(n3);
      // Wake was loaded before the worst-case pin rose, so it runs typical
      chk(n3, 27250, 27252, "worst-case mult two period");
      chk(ccnt, 16500, 16500, "mult two conversion");
      chk(tcnt, 0, 0, "temperature in third cycle");
      repeat (200) @(negedge mclk_in);
      chk(pd_w, 1, 1, "power-down after update");
      stop_test;
   end
endmodule

// *** testbench/ums_sched_assertions.sv ***
// Port-level timing checks of the update-mode scheduler
`timescale 1ns/1ns
`include "ums_defs.vh"
module ums_sched_assertions (
   input wire        mclk_in,
   input wire        rst_in,
   input wire        update_mode_in,
   input wire [1:0]  pd_sel_in,
   input wire [15:0] output_reg_out,
   input wire [15:0] temp_reg_out,
   input wire [15:0] pulse_density_output_cap_out,
   input wire [15:0] pulse_density_output_temp_out,
   input wire        data_ready_out,
   input wire        temp_conv_out,
   input wire        cap_conv_out,
   input wire        powered_down_out,
   input wire        cycle_done_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // Correction gap, typical up to worst case
   localparam int CALC_MIN = `UMS_US2CYC(`UMS_TEMP_CALC_US);
   localparam int CALC_MAX = (CALC_MIN * `UMS_WORST_TENTHS + 9) / 10;
   // Gap too long for a delay range, so it is counted here
   reg [15:0] gap_cnt_r;
   reg        in_gap_r;
   always @(posedge mclk_in) begin
      if (rst_in) begin
         gap_cnt_r <= 16'h0000;
         in_gap_r  <= 1'b0;
      end else if (temp_conv_out) begin
         gap_cnt_r <= 16'h0000;
         in_gap_r  <= 1'b1;
      end else if (cap_conv_out) begin
         in_gap_r  <= 1'b0;
      end else if (in_gap_r && gap_cnt_r != 16'hffff) begin
         gap_cnt_r <= gap_cnt_r + 16'h0001;
      end
   end
   sequence s_calc_then_cap;
      gap_cnt_r >= CALC_MIN && gap_cnt_r <= CALC_MAX;
   endsequence
   sequence s_update;
      cycle_done_out && data_ready_out;
   endsequence
   a_conv_exclusive: assert property (!(temp_conv_out && cap_conv_out))
      else $error("both conversions active");
   a_pd_quiet: assert property (powered_down_out |-> !temp_conv_out && !cap_conv_out)
      else $error("conversion while powered down");
   a_done_pulse: assert property (cycle_done_out |=> !cycle_done_out)
      else $error("cycle done longer than one clock");
   a_done_ready: assert property (cycle_done_out |-> s_update)
      else $error("update without ready");
   a_out_mirror: assert property (cycle_done_out |-> pulse_density_output_cap_out == output_reg_out
      && pulse_density_output_temp_out == temp_reg_out)
      else $error("density outputs differ from output register");
   a_out_hold: assert property (!cycle_done_out |-> $stable(output_reg_out))
      else $error("output register changed outside update");
   a_cap_after_temp: assert property ($rose(cap_conv_out) && in_gap_r |-> s_calc_then_cap)
      else $error("capacitance did not follow temperature");
   a_calc_bound: assert property (in_gap_r && !temp_conv_out |-> gap_cnt_r <= CALC_MAX)
      else $error("temperature correction too long");
   a_fast_rewake: assert property (cycle_done_out && pd_sel_in == 2'h0 && update_mode_in
      |-> ##[0:1] !powered_down_out)
      else $error("power-down entered with fastest rate");
   a_pd_entered: assert property (cycle_done_out && pd_sel_in != 2'h0
      |-> ##[0:1] powered_down_out)
      else $error("power-down not entered");
endmodule
bind ums_sched ums_sched_assertions ums_sched_assertions_i (
   .mclk_in(mclk_in), .rst_in(rst_in), .update_mode_in(update_mode_in),
   .pd_sel_in(pd_sel_in), .output_reg_out(output_reg_out), .temp_reg_out(temp_reg_out),
   .pulse_density_output_cap_out(pulse_density_output_cap_out),
   .pulse_density_output_temp_out(pulse_density_output_temp_out),
   .data_ready_out(data_ready_out), .temp_conv_out(temp_conv_out),
   .cap_conv_out(cap_conv_out), .powered_down_out(powered_down_out),
   .cycle_done_out(cycle_done_out));
